// ---- rtl/ric_reset_irq_ctrl.sv ----
// Reset sequencing, interrupt latches, priority encoder and control register
//
// Behaviour
// - Any reset fetches top vector, sets mask
// - Power-up holds reset, pulls pin low
// - Stay in reset while pin low
// - Supply-drop reset only while enable set
// - Mask bit blocks maskable interrupts
// - Entry stacks registers then sets mask
// - Return instruction restores registers, resumes
// - Requests wait for instruction boundary
// - Fixed priority with descending vectors
// - Software interrupt ignores mask, ordered
// - External latch cleared early in entry
// - Main enable gates pin, resets set
// - Option bit selects edge or level
// - Wired-OR low line re-requests after service
// - Second enable claims shared pin
// - Second input falling edge only
// - Second clear bit write-only, reads zero
// - Reset clears second latch; own vector
// - Key clear bit write-only, reads zero
//
// Added by the designer: the plain strobed port.
module ric_reset_irq_ctrl
	import ric_pkg::*;
#(
	parameter int STABILISE_COUNT = POWER_UP_STABILISE_COUNT
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// External reset pin, open drain
	input  wire logic        reset_pin_in,
	output logic             reset_pin_out,
	output logic             reset_pin_oe,
	input  wire logic        supply_below_threshold,
	// Interrupt pins and sources
	input  wire logic        ext_irq_pin_n,
	input  wire logic        shared_port_pin,
	input  wire logic        timer_irq_req,
	input  wire logic        key_edge_event,
	// Core handshake
	input  wire logic        instr_boundary,
	input  wire logic        swi_fetched,
	input  wire logic        rti_exec,
	input  wire logic        stacking_done,
	input  wire logic        cpu_mask_cleared,
	output logic             cpu_reset,
	output logic             irq_take,
	output logic             swi_take,
	output logic             restore_regs,
	output logic             push_regs,
	output logic      [12:0] vector_addr,
	output logic             mask_bit,
	output logic             second_pin_claimed,
	output logic             timer_ack,
	output logic             key_latch
);
	ric_por_state_t  por_q;
	logic [12:0]     por_cnt_q;
	logic [1:0]      rpin_sync_q;
	logic [1:0]      supply_sync_q;
	logic [1:0]      ext_sync_q;
	logic [1:0]      sec_sync_q;
	logic            ext_prev_q;
	logic            sec_prev_q;
	logic [7:0]      ctrl_q;
	logic [NUM_SRC-1:0] pend_q;
	logic            mask_q;
	logic            swi_pend_q;
	logic            in_entry_q;
	logic [12:0]     vector_q;
	logic            push_q;
	logic            restore_q;
	logic            take_q;
	logic            swi_take_q;
	logic            int_reset;
	logic            pin_low;
	logic            supply_low;
	logic            ext_fall;
	logic            sec_fall;
	logic            ext_cond;
	logic            ctrl_wr;
	logic [NUM_SRC-1:0] pend_en;
	logic            hw_go;
	logic            sw_go;

	function automatic logic [12:0] src_vector(input logic [NUM_SRC-1:0] p);
		logic [12:0] v;
		v = VEC_KEY;
		if (p[SRC_EXT]) begin
			v = VEC_EXT;
		end else if (p[SRC_SECOND]) begin
			v = VEC_SECOND;
		end else if (p[SRC_TIMER]) begin
			v = VEC_TIMER;
		end
		return v;
	endfunction

	// Pin synchronisers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rpin_sync_q   <= 2'h3;
			supply_sync_q <= 2'h0;
			ext_sync_q    <= 2'h3;
			sec_sync_q    <= 2'h3;
			ext_prev_q    <= 1'b1;
			sec_prev_q    <= 1'b1;
		end else begin
			rpin_sync_q   <= {rpin_sync_q[0], reset_pin_in};
			supply_sync_q <= {supply_sync_q[0], supply_below_threshold};
			ext_sync_q    <= {ext_sync_q[0], ext_irq_pin_n};
			sec_sync_q    <= {sec_sync_q[0], shared_port_pin};
			ext_prev_q    <= ext_sync_q[1];
			sec_prev_q    <= sec_sync_q[1];
		end
	end

	assign pin_low    = !rpin_sync_q[1];
	assign supply_low = supply_sync_q[1] && ctrl_q[BIT_SUPPLY_EN];
	assign ext_fall   = ext_prev_q && !ext_sync_q[1];
	assign sec_fall   = sec_prev_q && !sec_sync_q[1];
	assign int_reset  = (por_q != RIC_RUN) || pin_low || supply_low;

	// Power-up sequencer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			por_q     <= RIC_POR_COUNT;
			por_cnt_q <= 13'h0;
		end else begin
			case (por_q)
				RIC_POR_COUNT: begin
					if (por_cnt_q == 13'(STABILISE_COUNT - 1)) begin
						por_q <= pin_low ? RIC_POR_WAIT_PIN : RIC_RUN;
					end
					por_cnt_q <= por_cnt_q + 13'h1;
				end
				RIC_POR_WAIT_PIN: begin
					if (!pin_low) begin
						por_q <= RIC_RUN;
					end
				end
				RIC_RUN: begin
					por_q <= RIC_RUN;
				end
				default: begin
					por_q <= RIC_POR_COUNT;
				end
			endcase
		end
	end

	assign reset_pin_out = 1'b0;
	assign reset_pin_oe  = (por_q == RIC_POR_COUNT);
	assign cpu_reset     = int_reset;

	// Control register
	assign ctrl_wr = reg_wr && (reg_addr == MISC_CTRL_ADDR);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q <= MISC_CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_q <= reg_wdata;
			ctrl_q[BIT_SECOND_CLR] <= 1'b0;
			ctrl_q[BIT_KEY_CLR]    <= 1'b0;
		end
	end

	assign second_pin_claimed = ctrl_q[BIT_SECOND_EN];
	assign ext_cond = ctrl_q[BIT_EXT_EDGE] ? ext_fall : !ext_sync_q[1];

	// Pending latches; set wins over clear
	always_ff @(posedge clk) begin
		if (!rst_n || int_reset) begin
			pend_q <= '0;
		end else begin
			if (ctrl_q[BIT_EXT_EN] && ext_cond) begin
				pend_q[SRC_EXT] <= 1'b1;
			end else if (take_q && vector_q == VEC_EXT) begin
				pend_q[SRC_EXT] <= 1'b0;
			end
			if (ctrl_q[BIT_SECOND_EN] && sec_fall) begin
				pend_q[SRC_SECOND] <= 1'b1;
			end else if (ctrl_wr && reg_wdata[BIT_SECOND_CLR]) begin
				pend_q[SRC_SECOND] <= 1'b0;
			end
			pend_q[SRC_TIMER] <= timer_irq_req;
			if (ctrl_q[BIT_KEY_EN] && key_edge_event) begin
				pend_q[SRC_KEY] <= 1'b1;
			end else if (ctrl_wr && reg_wdata[BIT_KEY_CLR]) begin
				pend_q[SRC_KEY] <= 1'b0;
			end
		end
	end

	assign pend_en = pend_q;
	assign key_latch = pend_q[SRC_KEY];
	assign hw_go = instr_boundary && !in_entry_q && !mask_q && (|pend_en);
	assign sw_go = instr_boundary && !in_entry_q && !hw_go && swi_pend_q;

	// Software interrupt pending from its fetch
	always_ff @(posedge clk) begin
		if (!rst_n || int_reset) begin
			swi_pend_q <= 1'b0;
		end else if (swi_fetched) begin
			swi_pend_q <= 1'b1;
		end else if (sw_go) begin
			swi_pend_q <= 1'b0;
		end
	end

	// Entry sequence and mask bit
	always_ff @(posedge clk) begin
		if (!rst_n || int_reset) begin
			mask_q     <= 1'b1;
			vector_q   <= VEC_RESET;
			in_entry_q <= 1'b0;
			push_q     <= 1'b0;
			take_q     <= 1'b0;
			swi_take_q <= 1'b0;
			restore_q  <= 1'b0;
		end else begin
			take_q     <= hw_go;
			swi_take_q <= sw_go;
			restore_q  <= rti_exec;
			if (hw_go || sw_go) begin
				vector_q   <= hw_go ? src_vector(pend_en) : VEC_SOFT;
				in_entry_q <= 1'b1;
				push_q     <= 1'b1;
			end else if (in_entry_q && stacking_done) begin
				in_entry_q <= 1'b0;
				push_q     <= 1'b0;
				mask_q     <= 1'b1;
			end else if (cpu_mask_cleared || rti_exec) begin
				mask_q     <= 1'b0;
			end
		end
	end

	assign irq_take     = take_q;
	assign swi_take     = swi_take_q;
	assign push_regs    = push_q;
	assign restore_regs = restore_q;
	assign vector_addr  = vector_q;
	assign mask_bit     = mask_q;
	assign timer_ack    = take_q && (vector_q == VEC_TIMER);

	// Read port
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h0;
		end else if (reg_rd && reg_addr == MISC_CTRL_ADDR) begin
			reg_rdata <= ctrl_q;
		end else if (reg_rd && reg_addr == IRQ_STATUS_ADDR) begin
			reg_rdata <= {3'h0, mask_q, pend_q};
		end else begin
			reg_rdata <= 8'h0;
		end
	end

	a_reset_vector: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(int_reset) |-> vector_q == VEC_RESET && mask_q)
		else $error("reset did not load top vector and mask");
	a_stab_pin_pull: assert property (@(posedge clk) disable iff (!rst_n)
		por_q == RIC_POR_COUNT |-> reset_pin_oe && cpu_reset)
		else $error("reset pin not pulled during stabilisation");
	a_wait_pin_hold: assert property (@(posedge clk) disable iff (!rst_n)
		por_q == RIC_POR_WAIT_PIN |-> cpu_reset)
		else $error("released while pin low");
	a_supply_drop: assert property (@(posedge clk) disable iff (!rst_n)
		supply_sync_q[1] && ctrl_q[BIT_SUPPLY_EN] |-> cpu_reset)
		else $error("supply drop ignored while enabled");
	a_mask_blocks: assert property (@(posedge clk) disable iff (!rst_n)
		mask_q |=> !take_q)
		else $error("hardware interrupt taken while masked");
	sequence s_entry;
		(hw_go || sw_go) ##1 push_q;
	endsequence
	a_entry_push: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		(hw_go || sw_go) |-> s_entry)
		else $error("entry did not stack registers");
	a_boundary_only: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(take_q) |-> $past(instr_boundary))
		else $error("interrupt taken mid instruction");
	a_priority_ext: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		hw_go && pend_en[SRC_EXT] |=> vector_q == VEC_EXT)
		else $error("main pin not highest maskable");
	a_swi_unmasked: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		sw_go |=> vector_q == VEC_SOFT && swi_take_q)
		else $error("software interrupt not taken");
	a_clr_reads_zero: assert property (@(posedge clk) disable iff (!rst_n)
		!ctrl_q[BIT_SECOND_CLR] && !ctrl_q[BIT_KEY_CLR])
		else $error("write-only clear bit reads one");

	// Reset sources and power-up count
	a_pin_released: assert property (@(posedge clk) disable iff (!rst_n)
		por_q != RIC_POR_COUNT |-> !reset_pin_oe)
		else $error("reset pin pulled after stabilisation");
	a_count_end: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(reset_pin_oe) |-> por_cnt_q == 13'(STABILISE_COUNT))
		else $error("stabilisation count has wrong length");
	a_pin_reset: assert property (@(posedge clk) disable iff (!rst_n)
		pin_low |-> cpu_reset)
		else $error("low reset pin did not reset core");
	a_supply_ignored: assert property (@(posedge clk) disable iff (!rst_n)
		!ctrl_q[BIT_SUPPLY_EN] && por_q == RIC_RUN && !pin_low |-> !cpu_reset)
		else $error("supply drop acted while disabled");
	a_reset_clears: assert property (@(posedge clk) disable iff (!rst_n)
		int_reset |=> pend_q == '0 && !swi_pend_q)
		else $error("reset left a request pending");

	// Entry, stacking and return
	sequence s_stack_end;
		(in_entry_q && stacking_done) ##1 (mask_q && !push_q);
	endsequence
	a_stack_mask: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		in_entry_q && stacking_done |-> s_stack_end)
		else $error("mask not set after stacking");
	a_push_holds: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		push_q && !stacking_done |=> push_q)
		else $error("stacking request dropped early");
	sequence s_rti_restore;
		rti_exec ##1 restore_q;
	endsequence
	a_rti_restore: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		rti_exec |-> s_rti_restore)
		else $error("return did not restore registers");
	a_mask_clear: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		(cpu_mask_cleared || rti_exec) && !in_entry_q && !instr_boundary |=> !mask_q)
		else $error("mask not cleared");
	a_take_pulse: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		take_q |=> !take_q)
		else $error("interrupt taken twice in one entry");
	a_swi_masked: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		instr_boundary && !in_entry_q && swi_pend_q && mask_q |=> swi_take_q)
		else $error("software interrupt refused while masked");

	// Priority encoder and pending latches
	a_priority_second: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		hw_go && !pend_en[SRC_EXT] && pend_en[SRC_SECOND] |=> vector_q == VEC_SECOND)
		else $error("second pin lost its priority");
	a_priority_timer: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		hw_go && pend_en[SRC_TIMER] && !pend_en[SRC_EXT] && !pend_en[SRC_SECOND]
		|=> vector_q == VEC_TIMER)
		else $error("timer lost its priority");
	a_priority_key: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		hw_go && pend_en[SRC_KEY] && !(|pend_en[SRC_TIMER:SRC_EXT])
		|=> vector_q == VEC_KEY)
		else $error("key vector not used");
	a_ext_gate: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		!ctrl_q[BIT_EXT_EN] && !pend_q[SRC_EXT] |=> !pend_q[SRC_EXT])
		else $error("disabled main pin raised a request");
	a_level_sense: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		ctrl_q[BIT_EXT_EN] && !ctrl_q[BIT_EXT_EDGE] && !ext_sync_q[1]
		|=> pend_q[SRC_EXT])
		else $error("low level on main pin not latched");
	a_ext_clear: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		take_q && vector_q == VEC_EXT && !(ctrl_q[BIT_EXT_EN] && ext_cond)
		|=> !pend_q[SRC_EXT])
		else $error("main latch not cleared on entry");
	a_second_gate: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		!ctrl_q[BIT_SECOND_EN] && !pend_q[SRC_SECOND] |=> !pend_q[SRC_SECOND])
		else $error("disabled second pin raised a request");
	a_second_edge: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		!pend_q[SRC_SECOND] && !sec_fall |=> !pend_q[SRC_SECOND])
		else $error("second pin latched without a falling edge");
	a_second_clear: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		ctrl_wr && reg_wdata[BIT_SECOND_CLR] && !(ctrl_q[BIT_SECOND_EN] && sec_fall)
		|=> !pend_q[SRC_SECOND])
		else $error("second latch not cleared by write");
	a_key_clear: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		ctrl_wr && reg_wdata[BIT_KEY_CLR] && !(ctrl_q[BIT_KEY_EN] && key_edge_event)
		|=> !pend_q[SRC_KEY])
		else $error("key latch not cleared by write");
	a_timer_follows: assert property (@(posedge clk) disable iff (!rst_n || int_reset)
		timer_irq_req |=> pend_q[SRC_TIMER])
		else $error("timer request not latched");
endmodule

// ---- inc/ric_pkg.sv ----
// Package: register map, field positions, vectors and timing for reset/interrupt control
package ric_pkg;
	localparam logic [3:0]  MISC_CTRL_ADDR      = 4'hc;
	localparam logic [7:0]  MISC_CTRL_RESET     = 8'h10;
	// Status register offset (block state readback)
	localparam logic [3:0]  IRQ_STATUS_ADDR     = 4'hd;
	localparam int          BIT_SECOND_EN       = 0;
	localparam int          BIT_SECOND_CLR      = 1;
	localparam int          BIT_SPEED_SEL       = 2;
	localparam int          BIT_SUPPLY_EN       = 3;
	localparam int          BIT_EXT_EN          = 4;
	localparam int          BIT_EXT_EDGE        = 5;
	localparam int          BIT_KEY_CLR         = 6;
	localparam int          BIT_KEY_EN          = 7;
	// Vector high-byte addresses of each pair (low byte is +1)
	localparam logic [12:0] VEC_RESET           = 13'h1ffe;
	localparam logic [12:0] VEC_SOFT            = 13'h1ffc;
	localparam logic [12:0] VEC_EXT             = 13'h1ffa;
	localparam logic [12:0] VEC_SECOND          = 13'h1ff8;
	localparam logic [12:0] VEC_TIMER           = 13'h1ff6;
	localparam logic [12:0] VEC_KEY             = 13'h1ff4;
	// Power-up stabilisation count in bus cycles
	localparam int          POWER_UP_STABILISE_COUNT = 4064;
	// Least external reset width: 1.5 bus cycles, in tenths of a cycle
	localparam int          RESET_MIN_TENTHS    = 15;
	localparam int          RESET_MIN_CYCLES    = (RESET_MIN_TENTHS + 9) / 10;
	// Index of each maskable source in the pending vector
	localparam int          SRC_EXT             = 0;
	localparam int          SRC_SECOND          = 1;
	localparam int          SRC_TIMER           = 2;
	localparam int          SRC_KEY             = 3;
	localparam int          NUM_SRC             = 4;
	typedef enum logic [1:0] {
		RIC_POR_COUNT,
		RIC_POR_WAIT_PIN,
		RIC_RUN
	} ric_por_state_t;
endpackage

// ---- bench/ric_far_side.sv ----
// Far-side model: reset circuit with pull-up and the interrupt request sources
module ric_far_side
	import ric_pkg::*;
(
	input  wire logic clk,
	input  wire logic reset_req,
	input  wire logic reset_pin_oe,
	input  wire logic reset_pin_out,
	output logic      reset_pin_in,
	input  wire logic ext_req,
	output logic      ext_irq_pin_n,
	input  wire logic second_req,
	output logic      shared_port_pin,
	input  wire logic key_req,
	output logic      key_edge_event
);
	timeunit 1ns;
	timeprecision 1ps;
	int   hold_q = 0;
	logic key_q  = 1'h0;
	// A reset request is stretched so the pin never rises early
	always @(posedge clk) begin
		hold_q <= reset_req ? RESET_MIN_CYCLES + 1 : (hold_q > 0 ? hold_q - 1 : 0);
		key_q <= key_req;
	end
	// Pulled up; low while either party pulls it
	assign reset_pin_in = !((reset_pin_oe && !reset_pin_out) || reset_req || hold_q > 0);
	// Held as a level, never pulsed again inside a service routine
	assign ext_irq_pin_n = !ext_req;
	assign shared_port_pin = !second_req;
	assign key_edge_event = key_req && !key_q;
endmodule

// ---- bench/reset_and_interrupt_control_bench.sv ----
// Directed bench for the reset and interrupt controller
module reset_and_interrupt_control_bench import ric_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STAB = 8;
	logic        clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h0, reg_rdata;
	logic        supply_below_threshold = 1'h0, timer_irq_req = 1'h0, instr_boundary = 1'h0;
	logic        swi_fetched = 1'h0, rti_exec = 1'h0, stacking_done = 1'h0;
	logic        cpu_mask_cleared = 1'h0, reset_req = 1'h1, ext_req = 1'h0;
	logic        second_req = 1'h0, key_req = 1'h0;
	logic        reset_pin_in, reset_pin_out, reset_pin_oe, ext_irq_pin_n, shared_port_pin;
	logic        key_edge_event, cpu_reset, irq_take, swi_take, restore_regs, push_regs;
	logic        mask_bit, second_pin_claimed, timer_ack, key_latch;
	logic [12:0] vector_addr;
	int          miscompares = 0, compares = 0;
	always #5 clk = ~clk;
	ric_reset_irq_ctrl #(.STABILISE_COUNT(STAB)) ric_reset_irq_ctrl_i (.clk, .rst_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
		.supply_below_threshold, .ext_irq_pin_n, .shared_port_pin, .timer_irq_req,
		.key_edge_event, .instr_boundary, .swi_fetched, .rti_exec, .stacking_done,
		.cpu_mask_cleared, .cpu_reset, .irq_take, .swi_take, .restore_regs, .push_regs,
		.vector_addr, .mask_bit, .second_pin_claimed, .timer_ack, .key_latch);
	ric_far_side ric_far_side_i (.clk, .reset_req, .reset_pin_oe, .reset_pin_out,
		.reset_pin_in, .ext_req, .ext_irq_pin_n, .second_req, .shared_port_pin, .key_req,
		.key_edge_event);
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic wait_run(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
			if (cpu_reset === 1'h0) return;
		end
		chk(cpu_reset, 1'h0);
	endtask
	task automatic bnd(input logic sw);
		@(posedge clk);
		swi_fetched <= sw;
		@(posedge clk);
		swi_fetched <= 1'h0;
		instr_boundary <= 1'h1;
		@(posedge clk);
		instr_boundary <= 1'h0;
		#1;
	endtask
	task automatic serve(input logic sw, input logic [12:0] v);
		bnd(sw);
		chk({sw ? swi_take : irq_take, push_regs}, 2'h3);
		chk(vector_addr, v);
		chk(timer_ack, v === VEC_TIMER);
		@(posedge clk);
		stacking_done <= 1'h1;
		@(posedge clk);
		stacking_done <= 1'h0;
		#1 chk({push_regs, mask_bit}, 2'h1);
		@(posedge clk);
		rti_exec <= 1'h1;
		@(posedge clk);
		rti_exec <= 1'h0;
		#1 chk({restore_regs, mask_bit}, 2'h2);
	endtask
	task automatic results();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		cyc(3000);
		miscompares++;
		results();
	end
	initial begin
		cyc(4);
		#1 chk({cpu_reset, reset_pin_oe, mask_bit, vector_addr}, {3'h7, VEC_RESET});
		chk(reset_pin_out, 1'h0);
		cyc(8);
		rst_n <= 1'h1;
		cyc(STAB + 12);
		#1 chk({cpu_reset, reset_pin_oe}, 2'h2);
		@(posedge clk);
		reset_req <= 1'h0;
		wait_run(20);
		rdc(MISC_CTRL_ADDR, MISC_CTRL_RESET);
		rdc(IRQ_STATUS_ADDR, 8'h10);
		$display("reset test done");
		wr(MISC_CTRL_ADDR, 8'hff);
		rdc(MISC_CTRL_ADDR, 8'hbd);
		chk(second_pin_claimed, 1'h1);
		rdc(4'he, 8'h00);
		wr(MISC_CTRL_ADDR, 8'h10);
		#1 chk(second_pin_claimed, 1'h0);
		$display("register test done");
		@(posedge clk);
		timer_irq_req <= 1'h1;
		bnd(1'h0);
		chk(irq_take, 1'h0);
		serve(1'h1, VEC_SOFT);
		serve(1'h0, VEC_TIMER);
		@(posedge clk);
		timer_irq_req <= 1'h0;
		$display("mask test done");
		wr(MISC_CTRL_ADDR, 8'hb1);
		@(posedge clk);
		ext_req <= 1'h1;
		second_req <= 1'h1;
		timer_irq_req <= 1'h1;
		key_req <= 1'h1;
		cyc(5);
		rdc(IRQ_STATUS_ADDR, 8'h0f);
		chk(key_latch, 1'h1);
		serve(1'h0, VEC_EXT);
		serve(1'h0, VEC_SECOND);
		wr(MISC_CTRL_ADDR, 8'hb3);
		serve(1'h0, VEC_TIMER);
		@(posedge clk);
		timer_irq_req <= 1'h0;
		serve(1'h0, VEC_KEY);
		wr(MISC_CTRL_ADDR, 8'hf1);
		rdc(IRQ_STATUS_ADDR, 8'h00);
		chk(key_latch, 1'h0);
		$display("priority test done");
		wr(MISC_CTRL_ADDR, 8'h80);
		rdc(IRQ_STATUS_ADDR, 8'h00);
		wr(MISC_CTRL_ADDR, 8'h90);
		cyc(2);
		rdc(IRQ_STATUS_ADDR, 8'h01);
		serve(1'h0, VEC_EXT);
		serve(1'h0, VEC_EXT);
		$display("level test done");
		wr(MISC_CTRL_ADDR, 8'h01);
		@(posedge clk);
		ext_req <= 1'h0;
		second_req <= 1'h0;
		supply_below_threshold <= 1'h1;
		cyc(3);
		second_req <= 1'h1;
		cyc(6);
		#1 chk(cpu_reset, 1'h0);
		wr(MISC_CTRL_ADDR, 8'h09);
		cyc(6);
		#1 chk({cpu_reset, mask_bit, vector_addr}, {2'h3, VEC_RESET});
		@(posedge clk);
		supply_below_threshold <= 1'h0;
		wait_run(STAB + 20);
		rdc(IRQ_STATUS_ADDR, 8'h10);
		@(posedge clk);
		cpu_mask_cleared <= 1'h1;
		@(posedge clk);
		cpu_mask_cleared <= 1'h0;
		rdc(IRQ_STATUS_ADDR, 8'h00);
		$display("supply test done");
		results();
	end
endmodule
